// ===== dv/flc_ref_model.sv
`timescale 1ns/10ps
// Reference clock source; a stopped pin rests low
module flc_ref_model #(
  parameter realtime HALF = 40.3
) (
  input wire logic [2:0] runPins,
  output logic masterClkPin,
  output logic bitClkPin,
  output logic frameClkPin
);
  logic phase = 1'b0;
  logic [2:0] run_r = 3'h0;
  // 12.4 MHz, unrelated to the system clock, under the divided limit
  initial begin
    forever #(HALF) phase = ~phase;
  end
  // Gate only at a rising phase so no pin ever sees a runt pulse
  always @(posedge phase) begin
    run_r <= runPins;
  end
  assign masterClkPin = phase & run_r[0];
  assign bitClkPin = phase & run_r[1];
  assign frameClkPin = phase & run_r[2];
endmodule

// ===== dv/flc_top_assertions.sv
`timescale 1ns/10ps
// Port checks; shadows only the registers the properties need
module flc_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic gpioOut,
  input wire logic gpioOe_n,
  input wire logic fllClkOut,
  input wire logic fllLock,
  input wire logic irq
);
  logic wrPend_r;
  logic rdPend_r;
  logic [9:0] idx_r;
  logic [1:0] ctrl_r;
  logic frc_r;
  logic [5:0] frcVal_r;
  logic [3:0] sel_r;
  logic [1:0] mask_r;
  logic runOk;
  // Address phase; write data lands one edge later
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
    end else begin
      wrPend_r <= hsel && htrans[1] && hready && hwrite;
      rdPend_r <= hsel && htrans[1] && hready && !hwrite;
    end
    idx_r <= haddr[11:2];
  end
  // Shadow registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r <= 2'h0;
      frc_r <= 1'b0;
      frcVal_r <= 6'h19;
      sel_r <= 4'h0;
      mask_r <= 2'h0;
    end else if (wrPend_r) begin
      if (idx_r == flc_pkg::IDX_CTRL) ctrl_r <= hwdata[1:0];
      if (idx_r == flc_pkg::IDX_FRC_CTL) frc_r <= hwdata[0];
      if (idx_r == flc_pkg::IDX_FRC_VAL) frcVal_r <= hwdata[5:0];
      if (idx_r == flc_pkg::IDX_GPIO) sel_r <= hwdata[3:0];
      if (idx_r == flc_pkg::IDX_MASK) mask_r <= hwdata[1:0];
    end
  end
  // Words of 10h and up carry at least every 4 cycles, so even divide-by-64 toggles within 256
  assign runOk = ctrl_r == 2'h3 && frc_r && frcVal_r[5:4] != 2'h0;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence selHeld(logic [3:0] v);
    sel_r == v [*2];
  endsequence
  sequence runLong;
    runOk [*8];
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready or okay");
  a_read_forced: assert property (
    rdPend_r && idx_r == flc_pkg::IDX_FRC_VAL && !$past(wrPend_r) |-> hrdata == {26'h0, frcVal_r})
    else $error("forced value reads wrong");
  a_gpio_level: assert property (
    sel_r[3:1] == 3'h1 && $stable(sel_r) |-> gpioOut == sel_r[0] && !gpioOe_n)
    else $error("pin level wrong");
  a_gpio_lock: assert property (
    selHeld(flc_pkg::GPIO_LOCK) |-> !gpioOe_n && (gpioOut == fllLock || gpioOut == $past(fllLock)))
    else $error("pin does not show lock");
  a_gpio_clock: assert property (
    selHeld(flc_pkg::GPIO_FCLK) |-> !gpioOe_n && (gpioOut == fllClkOut || gpioOut == $past(fllClkOut)))
    else $error("pin does not show clock");
  a_irq_masked: assert property ((mask_r == 2'h0) [*2] |-> !irq) else $error("irq while masked");
  a_lock_normal: assert property ($rose(fllLock) |-> !frc_r) else $error("lock while forced");
  a_free_run: assert property (
    runLong |-> ##[1:300] ($changed(fllClkOut) || !runOk)) else $error("forced clock stalled");
endmodule

bind flc_top flc_checker chk (
  .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .gpioOut(gpioOut), .gpioOe_n(gpioOe_n),
  .fllClkOut(fllClkOut), .fllLock(fllLock), .irq(irq)
);

// ===== dv/fll_ref_and_freerun_control_test.sv
`timescale 1ns/10ps
// Host bench: registers over AHB-Lite, reference pins from the model
module fll_ref_and_freerun_control_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic gpioIn = 1'b0;
  logic [2:0] runPins = 3'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, masterClkPin, bitClkPin, frameClkPin;
  logic gpioOut, gpioOe_n, fllClkOut, fllLock, irq;
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  // Short silence limit keeps lock-loss waits brief; ref period is 16 cycles
  flc_top #(.REF_TIMEOUT(64)) dut (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .masterClkPin(masterClkPin),
    .bitClkPin(bitClkPin), .frameClkPin(frameClkPin), .gpioIn(gpioIn),
    .gpioOut(gpioOut), .gpioOe_n(gpioOe_n), .fllClkOut(fllClkOut), .fllLock(fllLock), .irq(irq)
  );
  flc_ref_model refSrc (
    .runPins(runPins), .masterClkPin(masterClkPin), .bitClkPin(bitClkPin), .frameClkPin(frameClkPin)
  );

  // 200 MHz clock
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Hang guard; the run needs about 4500 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors = errors + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One single transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {idx, 2'b00};
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic rdChk(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0, x);
    chk(x, exp);
  endtask
  task automatic waitLock(input logic exp, input int n);
    for (int i = 0; i < n && fllLock !== exp; i++) @(posedge sys_clk);
    chk({31'h0, fllLock}, {31'h0, exp});
  endtask
  // Counts output clock changes over n cycles
  task automatic edges(input int n, output int e);
    logic last;
    e = 0;
    last = fllClkOut;
    repeat (n) begin
      @(posedge sys_clk);
      if (fllClkOut !== last) e++;
      last = fllClkOut;
    end
  endtask

  task automatic testRegs();
    logic [5:0] v;
    rdChk(flc_pkg::IDX_CTRL, 32'h0000_0700);
    rdChk(flc_pkg::IDX_RATE, 32'h0000_0007);
    rdChk(flc_pkg::IDX_INTG, 32'h0000_2ee0);
    rdChk(flc_pkg::IDX_FRC_CTL, 32'h0);
    rdChk(flc_pkg::IDX_FRC_VAL, 32'h0000_0019);
    wr(10'h3ff, 32'hffff_ffff);
    rdChk(10'h3ff, 32'h0);
    wr(flc_pkg::IDX_FRAC, 32'hffff_ffff);
    rdChk(flc_pkg::IDX_FRAC, 32'h0000_ffff);
    wr(flc_pkg::IDX_INTG, 32'hffff_ffff);
    rdChk(flc_pkg::IDX_INTG, 32'h0000_7fef);
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'h19;
      wr(flc_pkg::IDX_FRC_VAL, {26'h0, v});
      rdChk(flc_pkg::IDX_FRC_VAL, {26'h0, v});
    end
    $display("testRegs finished");
  endtask
  // Each of the three source codes locks on its own pin and not on the next one, the reserved code not on the bit pin; lock events reach status and irq
  task automatic testLock();
    int e;
    // N.K = 255.5 with fractional mode on, so the loop word uses both fields
    wr(flc_pkg::IDX_RATE, 32'h0);
    wr(flc_pkg::IDX_FRAC, 32'h0000_8000);
    wr(flc_pkg::IDX_INTG, 32'h0000_1fe0);
    wr(flc_pkg::IDX_GPIO, {28'h0, flc_pkg::GPIO_LOCK});
    // Oscillator enable off: once the reference stops only the held word keeps it running
    wr(flc_pkg::IDX_CTRL, 32'h0000_0705);
    for (int s = 0; s < 4; s++) begin
      if (s == 1) wr(flc_pkg::IDX_MASK, 32'h1);
      wr(flc_pkg::IDX_REF, 32'(s));
      runPins <= 3'(1 << ((s + 1) % 3));
      repeat (400) @(posedge sys_clk);
      chk({31'h0, fllLock}, 32'h0);
      if (s < 3) begin
        runPins <= 3'(1 << s);
        waitLock(1'b1, 1000);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq}, 32'(s != 0));
        rdChk(flc_pkg::IDX_STAT, (s == 0) ? 32'h1 : 32'h3);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        runPins <= 3'h0;
        edges(300, e);
        chk({31'h0, e != 0}, 32'h1);
        waitLock(1'b0, 400);
      end
    end
    runPins <= 3'h0;
    $display("testLock finished");
  endtask
  // Free-run from the forced word, then the pin functions
  task automatic testFree();
    int e1;
    int e2;
    wr(flc_pkg::IDX_REF, 32'h0);
    runPins <= 3'h1;
    wr(flc_pkg::IDX_CTRL, 32'h0000_0703);
    wr(flc_pkg::IDX_FRC_CTL, 32'h1);
    wr(flc_pkg::IDX_FRC_VAL, 32'h19);
    repeat (400) @(posedge sys_clk);
    chk({31'h0, fllLock}, 32'h0);
    runPins <= 3'h0;
    wr(flc_pkg::IDX_GPIO, {28'h0, flc_pkg::GPIO_FCLK});
    edges(300, e1);
    chk({31'h0, e1 != 0}, 32'h1);
    chk({31'h0, gpioOe_n}, 32'h0);
    wr(flc_pkg::IDX_FRC_VAL, 32'h20);
    edges(300, e2);
    chk({31'h0, e2 > e1}, 32'h1);
    for (int g = 2; g < 4; g++) begin
      wr(flc_pkg::IDX_GPIO, 32'(g));
      repeat (3) @(posedge sys_clk);
      chk({30'h0, gpioOe_n, gpioOut}, 32'(g - 2));
    end
    gpioIn <= 1'b1;
    wr(flc_pkg::IDX_GPIO, 32'h0);
    repeat (4) @(posedge sys_clk);
    chk({30'h0, gpioOe_n, gpioOut}, 32'h3);
    $display("testFree finished");
  endtask

  // Reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    testRegs();
    testLock();
    testFree();
    summarize();
  end
endmodule

// ===== hw/flc_nco.sv
`timescale 1ns/10ps
// Digital stand-in for the oscillator and its output divider
module flc_nco #(
  parameter int INC_W = 26
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [INC_W-1:0] incr,
  input wire logic [5:0] outDiv,
  output logic fllClk
);
  logic [INC_W-1:0] acc_r;
  logic [INC_W:0] sum;
  logic [5:0] divCnt_r;

  // Accumulators narrower than 8 bits are refused at elaboration
  if (INC_W < 8) begin : gBadWidth
    $error("flc_nco: INC_W too small");
  end

  assign sum = {1'b0, acc_r} + {1'b0, incr};

  // Carry out of the accumulator is one oscillator half-period tick
  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      acc_r <= '0;
      divCnt_r <= '0;
      fllClk <= 1'b0;
    end else begin
      acc_r <= sum[INC_W-1:0];
      if (sum[INC_W]) begin
        // Divide by outDiv+1 ticks per output half-period
        if (divCnt_r >= outDiv) begin
          divCnt_r <= '0;
          fllClk <= ~fllClk;
        end else begin
          divCnt_r <= divCnt_r + 6'h01;
        end
      end
    end
  end
endmodule

// ===== hw/flc_pkg.sv
package flc_pkg;
  // Register word indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h074;
  localparam logic [9:0] IDX_RATE = 10'h075;
  localparam logic [9:0] IDX_FRAC = 10'h076;
  localparam logic [9:0] IDX_INTG = 10'h077;
  localparam logic [9:0] IDX_REF = 10'h078;
  localparam logic [9:0] IDX_GPIO = 10'h079;
  localparam logic [9:0] IDX_STAT = 10'h07c;
  localparam logic [9:0] IDX_MASK = 10'h07d;
  localparam logic [9:0] IDX_STATE = 10'h07e;
  localparam logic [9:0] IDX_FRC_CTL = 10'h0f7;
  localparam logic [9:0] IDX_FRC_VAL = 10'h0f8;

  // Field positions
  localparam int CTRL_ENA_BIT = 0;
  localparam int CTRL_OSC_BIT = 1;
  localparam int CTRL_FRACN_BIT = 2;
  localparam int CTRL_OUTDIV_LSB = 8;
  localparam int RATE_CRATE_LSB = 4;
  localparam int INTG_N_LSB = 5;
  localparam int REF_DIV_LSB = 3;
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_UNLOCK_BIT = 1;

  // Reset values
  localparam logic [5:0] OUTDIV_RST = 6'h07;
  localparam logic [2:0] RATIO_RST = 3'h7;
  localparam logic [2:0] CRATE_RST = 3'h0;
  localparam logic [15:0] FRAC_RST = 16'h0000;
  localparam logic [9:0] INTG_RST = 10'h177;
  localparam logic [3:0] GAIN_RST = 4'h0;
  localparam logic [5:0] FRC_VAL_RST = 6'h19;

  // Reference source codes
  localparam logic [1:0] REF_MCLK = 2'h0;
  localparam logic [1:0] REF_BCLK = 2'h1;
  localparam logic [1:0] REF_FCLK = 2'h2;

  // GPIO function codes
  localparam logic [3:0] GPIO_LOW = 4'h2;
  localparam logic [3:0] GPIO_HIGH = 4'h3;
  localparam logic [3:0] GPIO_LOCK = 4'h5;
  localparam logic [3:0] GPIO_FCLK = 4'h9;

  // Timing: a reference silent this long counts as stopped
  localparam int SYS_CLK_MHZ = 200;
  localparam int REF_TIMEOUT_US = 10;
  localparam int REF_TIMEOUT_CYC = REF_TIMEOUT_US * SYS_CLK_MHZ;
  localparam int LOCK_EDGES = 16;
endpackage

// ===== hw/flc_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for pin levels
module flc_sync #(
  parameter int WIDTH = 3
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_r;

  // At least one pin must pass through
  if (WIDTH < 1) begin : gBadWidth
    $error("flc_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_r <= '0;
      syncOut <= '0;
    end else begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end
endmodule

// ===== hw/flc_top.sv
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
// What this block does
// - Two-bit source select picks master, bit or frame clock; code 11 reserved.
// - Oscillator runs and gives a clock without any reference present.
// - After a valid start, output keeps running if the reference stops.
// - Forced select 0 is normal loop; 1 drives oscillator from forced value.
// - Forced value is six bits, full range, resets to 011001.
// - Lock indication feeds the interrupt logic as an event.
// - Lock indication can be routed to the general-purpose pin.
// - FLL clock can be routed to the general-purpose pin regardless.
// - Sixteen-bit fractional field has MSB weight one half.
// - Ten-bit integer field sits at bits 14 to 5, LSB weight one.
module flc_top #(
  parameter int REF_TIMEOUT = flc_pkg::REF_TIMEOUT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic masterClkPin,
  input wire logic bitClkPin,
  input wire logic frameClkPin,
  input wire logic gpioIn,
  output logic gpioOut,
  output logic gpioOe_n,
  output logic fllClkOut,
  output logic fllLock,
  output logic irq
);
  logic fllEnable_r, fllAnalogOscEnable_r, fllFractionalEnable_r;
  logic [5:0] fllOutputDivider_r;
  logic [2:0] fllRatioDivisor_r, fllControlRateDiv_r;
  logic [15:0] fllFractionMultiplier_r;
  logic [9:0] fllIntegerMultiplier_r;
  logic [3:0] fllLoopGain_r, gpioSel_r;
  logic [1:0] fllRefPredivider_r, fllRefSourceSel_r;
  logic fllForcedOscSelect_r;
  logic [5:0] fllForcedOscValue_r;
  logic [1:0] status_r, mask_r, statusSet;
  logic wrPend_r;
  logic [9:0] wrIdx_r;
  logic [3:0] refSync;
  logic refLvl, refPrev_r, refEdge;
  logic [2:0] preCnt_r;
  logic refTick;
  logic [$clog2(REF_TIMEOUT+1)-1:0] silentCnt_r;
  logic refActive;
  logic [4:0] lockCnt_r;
  logic lock_r, lockPrev_r, heldValid_r;
  logic [25:0] loopWord_r, ncoIncr;
  logic ncoRun, ncoClk;
  logic addrPhase, rdStat;
  logic [31:0] rdData;

  // A silence limit below 2 leaves no window in which an edge can arrive
  if (REF_TIMEOUT < 2) begin : gBadTimeout
    $error("flc_top: REF_TIMEOUT must be at least 2");
  end

  // Word index of a bus byte address
  function automatic logic [9:0] wordIdx(input logic [11:0] a);
    return a[11:2];
  endfunction

  // Ratio divisor code to right shift: 1,2,4,8,16
  function automatic logic [2:0] ratioShift(input logic [2:0] code);
    return code[2] ? 3'h4 : code;
  endfunction

  assign addrPhase = hsel && htrans[1] && hready;
  assign rdStat = addrPhase && !hwrite && wordIdx(haddr) == flc_pkg::IDX_STAT;

  // Bus answers with zero wait states and always OKAY
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Write address captured in address phase, data applied in data phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPend_r <= 1'b0;
      wrIdx_r <= '0;
    end else begin
      wrPend_r <= addrPhase && hwrite;
      wrIdx_r <= wordIdx(haddr);
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fllEnable_r <= 1'b0;
      fllAnalogOscEnable_r <= 1'b0;
      fllFractionalEnable_r <= 1'b0;
      fllOutputDivider_r <= flc_pkg::OUTDIV_RST;
      fllRatioDivisor_r <= flc_pkg::RATIO_RST;
      fllControlRateDiv_r <= flc_pkg::CRATE_RST;
      fllFractionMultiplier_r <= flc_pkg::FRAC_RST;
      fllIntegerMultiplier_r <= flc_pkg::INTG_RST;
      fllLoopGain_r <= flc_pkg::GAIN_RST;
      fllRefPredivider_r <= 2'h0;
      fllRefSourceSel_r <= flc_pkg::REF_MCLK;
      gpioSel_r <= 4'h0;
      fllForcedOscSelect_r <= 1'b0;
      fllForcedOscValue_r <= flc_pkg::FRC_VAL_RST;
      mask_r <= 2'h0;
    end else if (wrPend_r) begin
      unique case (wrIdx_r)
        flc_pkg::IDX_CTRL: begin
          fllEnable_r <= hwdata[flc_pkg::CTRL_ENA_BIT];
          fllAnalogOscEnable_r <= hwdata[flc_pkg::CTRL_OSC_BIT];
          fllFractionalEnable_r <= hwdata[flc_pkg::CTRL_FRACN_BIT];
          fllOutputDivider_r <= hwdata[flc_pkg::CTRL_OUTDIV_LSB +: 6];
        end
        flc_pkg::IDX_RATE: begin
          fllRatioDivisor_r <= hwdata[2:0];
          fllControlRateDiv_r <= hwdata[flc_pkg::RATE_CRATE_LSB +: 3];
        end
        flc_pkg::IDX_FRAC: fllFractionMultiplier_r <= hwdata[15:0];
        flc_pkg::IDX_INTG: begin
          fllIntegerMultiplier_r <= hwdata[flc_pkg::INTG_N_LSB +: 10];
          fllLoopGain_r <= hwdata[3:0];
        end
        flc_pkg::IDX_REF: begin
          fllRefPredivider_r <= hwdata[flc_pkg::REF_DIV_LSB +: 2];
          fllRefSourceSel_r <= hwdata[1:0];
        end
        flc_pkg::IDX_GPIO: gpioSel_r <= hwdata[3:0];
        flc_pkg::IDX_MASK: mask_r <= hwdata[1:0];
        flc_pkg::IDX_FRC_CTL: fllForcedOscSelect_r <= hwdata[0];
        flc_pkg::IDX_FRC_VAL: fllForcedOscValue_r <= hwdata[5:0];
        default: ;
      endcase
    end
  end

  // Read mux, registered at the address phase so data stands in the data phase
  always_comb begin
    rdData = 32'h0000_0000;
    unique case (wordIdx(haddr))
      flc_pkg::IDX_CTRL: rdData = {18'h0, fllOutputDivider_r, 5'h0, fllFractionalEnable_r,
                                   fllAnalogOscEnable_r, fllEnable_r};
      flc_pkg::IDX_RATE: rdData = {25'h0, fllControlRateDiv_r, 1'b0, fllRatioDivisor_r};
      flc_pkg::IDX_FRAC: rdData = {16'h0, fllFractionMultiplier_r};
      flc_pkg::IDX_INTG: rdData = {17'h0, fllIntegerMultiplier_r, 1'b0, fllLoopGain_r};
      flc_pkg::IDX_REF: rdData = {27'h0, fllRefPredivider_r, 1'b0, fllRefSourceSel_r};
      flc_pkg::IDX_GPIO: rdData = {28'h0, gpioSel_r};
      flc_pkg::IDX_STAT: rdData = {30'h0, status_r};
      flc_pkg::IDX_MASK: rdData = {30'h0, mask_r};
      flc_pkg::IDX_STATE: rdData = {28'h0, fllForcedOscSelect_r, refActive, heldValid_r, lock_r};
      flc_pkg::IDX_FRC_CTL: rdData = {31'h0, fllForcedOscSelect_r};
      flc_pkg::IDX_FRC_VAL: rdData = {26'h0, fllForcedOscValue_r};
      default: rdData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= rdData;
    end
  end

  // Reference pins and the pin input are asynchronous to sys_clk
  flc_sync #(.WIDTH(4)) refSyncI (
    .sys_clk(sys_clk),
    .rst(rst),
    .asyncIn({gpioIn, frameClkPin, bitClkPin, masterClkPin}),
    .syncOut(refSync)
  );

  // Source select; the reserved code gives no reference
  always_comb begin
    unique case (fllRefSourceSel_r)
      flc_pkg::REF_MCLK: refLvl = refSync[0];
      flc_pkg::REF_BCLK: refLvl = refSync[1];
      flc_pkg::REF_FCLK: refLvl = refSync[2];
      default: refLvl = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      refPrev_r <= 1'b0;
    end else begin
      refPrev_r <= refLvl;
    end
  end
  assign refEdge = refLvl && !refPrev_r;

  // Reference pre-divider: one tick per 1, 2, 4 or 8 edges
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      preCnt_r <= 3'h0;
    end else if (refEdge) begin
      preCnt_r <= preCnt_r + 3'h1;
    end
  end
  assign refTick = refEdge && ((preCnt_r & ((3'h1 << fllRefPredivider_r) - 3'h1)) == 3'h0);

  // Silence timer: the reference counts as present while edges keep coming
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      silentCnt_r <= ($clog2(REF_TIMEOUT+1))'(REF_TIMEOUT);
    end else if (refEdge) begin
      silentCnt_r <= '0;
    end else if (silentCnt_r != ($clog2(REF_TIMEOUT+1))'(REF_TIMEOUT)) begin
      silentCnt_r <= silentCnt_r + 1'b1;
    end
  end
  assign refActive = silentCnt_r != ($clog2(REF_TIMEOUT+1))'(REF_TIMEOUT);

  // Loop word follows N.K while referenced, then holds so the clock continues
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      loopWord_r <= {flc_pkg::INTG_RST, flc_pkg::FRAC_RST};
      heldValid_r <= 1'b0;
    end else if (fllEnable_r && !fllForcedOscSelect_r && refActive && refTick) begin
      // K is ignored unless fractional mode is on
      loopWord_r <= {fllIntegerMultiplier_r,
                     fllFractionalEnable_r ? fllFractionMultiplier_r : 16'h0000}
                    >> ratioShift(fllRatioDivisor_r);
      heldValid_r <= 1'b1;
    end else if (!fllEnable_r) begin
      heldValid_r <= 1'b0;
    end
  end

  // Forced select replaces the loop word with the forced value
  assign ncoIncr = fllForcedOscSelect_r ? {fllForcedOscValue_r, 20'h0_0000} : loopWord_r;
  // Runs with the oscillator enable, or from the held word, even with no reference
  assign ncoRun = fllEnable_r && (fllAnalogOscEnable_r || heldValid_r);

  flc_nco #(.INC_W(26)) ncoI (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(ncoRun),
    .incr(ncoIncr),
    .outDiv(fllOutputDivider_r),
    .fllClk(ncoClk)
  );

  // Lock after a run of reference ticks; lost when the reference goes quiet
  always_ff @(posedge sys_clk) begin
    if (rst || !fllEnable_r || fllForcedOscSelect_r || !refActive) begin
      lockCnt_r <= 5'h00;
      lock_r <= 1'b0;
    end else if (refTick) begin
      if (lockCnt_r == 5'(flc_pkg::LOCK_EDGES - 1)) begin
        lock_r <= 1'b1;
      end else begin
        lockCnt_r <= lockCnt_r + 5'h01;
      end
    end
  end

  // Lock edges are interrupt events; set wins over read-clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lockPrev_r <= 1'b0;
      status_r <= 2'h0;
      irq <= 1'b0;
    end else begin
      lockPrev_r <= lock_r;
      status_r <= (status_r & ~{2{rdStat}}) | statusSet;
      irq <= |(status_r & mask_r);
    end
  end
  assign statusSet[flc_pkg::STAT_LOCK_BIT] = lock_r && !lockPrev_r;
  assign statusSet[flc_pkg::STAT_UNLOCK_BIT] = !lock_r && lockPrev_r;

  // Pin and clock outputs, all registered
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gpioOut <= 1'b0;
      gpioOe_n <= 1'b1;
      fllClkOut <= 1'b0;
      fllLock <= 1'b0;
    end else begin
      fllClkOut <= ncoClk;
      fllLock <= lock_r;
      unique case (gpioSel_r)
        flc_pkg::GPIO_LOW: begin
          gpioOut <= 1'b0;
          gpioOe_n <= 1'b0;
        end
        flc_pkg::GPIO_HIGH: begin
          gpioOut <= 1'b1;
          gpioOe_n <= 1'b0;
        end
        flc_pkg::GPIO_LOCK: begin
          gpioOut <= lock_r;
          gpioOe_n <= 1'b0;
        end
        flc_pkg::GPIO_FCLK: begin
          gpioOut <= ncoClk;
          gpioOe_n <= 1'b0;
        end
        default: begin
          gpioOut <= refSync[3];
          gpioOe_n <= 1'b1;
        end
      endcase
    end
  end
endmodule
